// file: dual_ctr_pkg.sv
package dual_ctr_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [3:0] IDX_SHORT_CTRL = 4'h0;
    localparam logic [3:0] IDX_COMMON_CTRL = 4'h1;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h2;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h3;
    localparam logic [3:0] IDX_CAPTURE_LOW = 4'h4;
    localparam logic [3:0] IDX_CAPTURE_HIGH = 4'h5;

    // Field positions of the common control register.
    localparam int COMMON_MODE_BIT = 7;
    localparam int COMMON_PIN_BIT = 6;
    localparam int COMMON_FUNC_HI = 5;
    localparam int COMMON_FUNC_LO = 4;
    localparam int COMMON_RISE_FLAG_BIT = 1;
    localparam int COMMON_FALL_FLAG_BIT = 0;

    // Field positions of the short control register.
    localparam int SHORT_CAPTURE_IE_BIT = 2;
    localparam int SHORT_COUNTER_IE_BIT = 1;
    localparam int SHORT_FIRST_PIN_BIT = 0;

    // Interrupt status and mask layout.
    localparam int IRQ_CAPTURE_BIT = 0;
    localparam int IRQ_TIMEOUT_BIT = 1;

    // Reset values.
    localparam logic [7:0] COMMON_CTRL_RESET = 8'h00;
    localparam logic [7:0] SHORT_CTRL_RESET = 8'h00;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // Mode and function encodings.
    localparam logic MODE_TRANSMIT = 1'b0;
    localparam logic MODE_DEMOD = 1'b1;
    localparam logic [1:0] FUNC_AND = 2'h0;
    localparam logic [1:0] FUNC_OR = 2'h1;
    localparam logic [1:0] FUNC_NOR = 2'h2;
    localparam logic [1:0] FUNC_NAND = 2'h3;
    localparam logic [1:0] EDGE_FALLING = 2'h0;
    localparam logic [1:0] EDGE_RISING = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_RESERVED = 2'h3;

endpackage

// file: pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous pin and its filtered level.
    input wire logic pin_i,
    output logic level_o
);

    logic meta_q;
    logic second_q;
    logic third_q;

    // Three stages; the first is read only by the second.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            second_q <= 1'b0;
            third_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            second_q <= meta_q;
            third_q <= second_q;
        end
    end

    // A change is accepted only once the last two stages agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else if (second_q == third_q) begin
            level_o <= third_q;
        end
    end

endmodule

`default_nettype wire

// file: edge_finder.sv
`timescale 1ns/1ps
`default_nettype none

module edge_finder (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Level under watch and the edge kind wanted.
    input wire logic level_i,
    input wire logic enable_i,
    input wire logic [1:0] kind_i,
    // One-cycle pulses for accepted edges.
    output logic rise_o,
    output logic fall_o
);

    logic prev_q;
    logic raw_rise;
    logic raw_fall;

    // Previous level; held at reset so no edge appears at release.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level_i;
        end
    end

    assign raw_rise = level_i & ~prev_q;
    assign raw_fall = ~level_i & prev_q;

    // The reserved kind matches nothing, so no edge is reported.
    always_comb begin
        rise_o = 1'b0;
        fall_o = 1'b0;
        if (enable_i) begin
            unique case (kind_i)
                dual_ctr_pkg::EDGE_FALLING: fall_o = raw_fall;
                dual_ctr_pkg::EDGE_RISING: rise_o = raw_rise;
                dual_ctr_pkg::EDGE_BOTH: begin
                    rise_o = raw_rise;
                    fall_o = raw_fall;
                end
                dual_ctr_pkg::EDGE_RESERVED: begin
                    rise_o = 1'b0;
                    fall_o = 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// file: dual_counter_transmit_demod_ctrl.sv
// Function
// - Capture with enable raises an interrupt.
// - Eight-bit timeout with enable raises interrupt.
// - Control bit routes eight-bit output to pin.
// - Bit 7 selects transmit or demodulation mode.
// - Transmit bit 6 routes combined output out.
// - Demod bit 6 picks the input pin.
// - Transmit bits 5:4 pick AND/OR/NOR/NAND.
// - Demod bits 5:4 pick falling/rising/both.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module dual_counter_transmit_demod_ctrl (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Counter outputs, timeout and count from the counters.
    input wire logic eight_bit_out_i,
    input wire logic sixteen_bit_out_i,
    input wire logic eight_bit_timeout_i,
    input wire logic [15:0] capture_count_i,
    // Port data latches for the timer pins.
    input wire logic first_port_data_i,
    input wire logic second_port_data_i,
    // Demodulator source pins.
    input wire logic comparator_capable_input_pin_i,
    input wire logic alternate_port_two_pin_i,
    // Pins and interrupt.
    output logic first_timer_output_pin_o,
    output logic second_timer_output_pin_o,
    output logic capture_pulse_o,
    output logic irq_o
);

    logic [7:0] timer_common_control_q;
    logic [7:0] short_timer_control_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic [7:0] capture_low_byte_q;
    logic [7:0] capture_high_byte_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [1:0] read_clear_q;
    logic capture_pulse_q;
    logic [3:0] reg_idx;
    logic bus_write;
    logic bus_read_done;
    logic demod_mode;
    logic [1:0] combine_or_edge_select;
    logic cmp_level;
    logic alt_level;
    logic demod_level;
    logic combined;
    logic rise_ev;
    logic fall_ev;
    logic edge_ev;
    logic [1:0] irq_events;

    assign reg_idx = adr_i[5:2];
    assign demod_mode = timer_common_control_q[dual_ctr_pkg::COMMON_MODE_BIT];
    assign combine_or_edge_select =
        timer_common_control_q[dual_ctr_pkg::COMMON_FUNC_HI:dual_ctr_pkg::COMMON_FUNC_LO];
    // Register effects land on the edge at which ack is seen high.
    assign bus_write = cyc_i & stb_i & ack_q & we_i & sel_i[0];
    assign bus_read_done = cyc_i & stb_i & ack_q & ~we_i;
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign capture_pulse_o = capture_pulse_q;

    // Both source pins are filtered; a mode switch then sees a settled level.
    pin_sync u_sync_cmp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(comparator_capable_input_pin_i),
        .level_o(cmp_level)
    );

    pin_sync u_sync_alt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(alternate_port_two_pin_i),
        .level_o(alt_level)
    );

    assign demod_level = timer_common_control_q[dual_ctr_pkg::COMMON_PIN_BIT] ?
        alt_level : cmp_level;

    edge_finder u_edges (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(demod_level),
        .enable_i(demod_mode),
        .kind_i(combine_or_edge_select),
        .rise_o(rise_ev),
        .fall_o(fall_ev)
    );

    assign edge_ev = rise_ev | fall_ev;

    always_comb begin
        unique case (combine_or_edge_select)
            dual_ctr_pkg::FUNC_AND: combined = eight_bit_out_i & sixteen_bit_out_i;
            dual_ctr_pkg::FUNC_OR: combined = eight_bit_out_i | sixteen_bit_out_i;
            dual_ctr_pkg::FUNC_NOR: combined = ~(eight_bit_out_i | sixteen_bit_out_i);
            dual_ctr_pkg::FUNC_NAND: combined = ~(eight_bit_out_i & sixteen_bit_out_i);
        endcase
    end

    // Bus handshake: one wait state, ack drops the cycle after it rises.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
        end
    end

    // Read data is captured with ack; the status bits read are remembered
    // so only those are cleared and a later event is never lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
            read_clear_q <= 2'h0;
        end else if (cyc_i & stb_i & ~ack_q) begin
            dat_q <= 32'h0000_0000;
            read_clear_q <= 2'h0;
            unique case (reg_idx)
                dual_ctr_pkg::IDX_SHORT_CTRL: dat_q[7:0] <= short_timer_control_q;
                dual_ctr_pkg::IDX_COMMON_CTRL: dat_q[7:0] <= timer_common_control_q;
                dual_ctr_pkg::IDX_IRQ_STATUS: begin
                    dat_q[1:0] <= irq_status_q;
                    read_clear_q <= we_i ? 2'h0 : irq_status_q;
                end
                dual_ctr_pkg::IDX_IRQ_MASK: dat_q[1:0] <= irq_mask_q;
                dual_ctr_pkg::IDX_CAPTURE_LOW: dat_q[7:0] <= capture_low_byte_q;
                dual_ctr_pkg::IDX_CAPTURE_HIGH: dat_q[7:0] <= capture_high_byte_q;
                default: dat_q <= 32'h0000_0000;
            endcase
        end
    end

    // mode switch assumes stopped counters.
    // Edge flags in bits 1:0 are set by hardware; in demodulation mode writing a one clears them, in transmit mode a write loads them;
    // a set in the same cycle wins over the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_common_control_q <= dual_ctr_pkg::COMMON_CTRL_RESET;
        end else begin
            if (bus_write && reg_idx == dual_ctr_pkg::IDX_COMMON_CTRL) begin
                timer_common_control_q[7:2] <= dat_i[7:2];
                if (demod_mode) begin
                    timer_common_control_q[1:0] <= timer_common_control_q[1:0] & ~dat_i[1:0];
                end else begin
                    timer_common_control_q[1:0] <= dat_i[1:0];
                end
            end
            if (rise_ev) begin
                timer_common_control_q[dual_ctr_pkg::COMMON_RISE_FLAG_BIT] <= 1'b1;
            end
            if (fall_ev) begin
                timer_common_control_q[dual_ctr_pkg::COMMON_FALL_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // Short control holds interrupt enables and the first pin select.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            short_timer_control_q <= dual_ctr_pkg::SHORT_CTRL_RESET;
            irq_mask_q <= dual_ctr_pkg::IRQ_MASK_RESET;
        end else if (bus_write) begin
            if (reg_idx == dual_ctr_pkg::IDX_SHORT_CTRL) begin
                short_timer_control_q <= dat_i[7:0];
            end
            if (reg_idx == dual_ctr_pkg::IDX_IRQ_MASK) begin
                irq_mask_q <= dat_i[1:0];
            end
        end
    end

    // Count is captured on every accepted edge in demodulation mode.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_low_byte_q <= 8'h00;
            capture_high_byte_q <= 8'h00;
            capture_pulse_q <= 1'b0;
        end else begin
            capture_pulse_q <= edge_ev;
            if (edge_ev) begin
                capture_low_byte_q <= capture_count_i[7:0];
                capture_high_byte_q <= capture_count_i[15:8];
            end
        end
    end

    assign irq_events[dual_ctr_pkg::IRQ_CAPTURE_BIT] = edge_ev &
        short_timer_control_q[dual_ctr_pkg::SHORT_CAPTURE_IE_BIT];
    assign irq_events[dual_ctr_pkg::IRQ_TIMEOUT_BIT] = eight_bit_timeout_i &
        short_timer_control_q[dual_ctr_pkg::SHORT_COUNTER_IE_BIT];

    // Sticky status; a read clears only what it returned, and a new event wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_q <= 2'h0;
        end else if (bus_read_done) begin
            irq_status_q <= (irq_status_q & ~read_clear_q) | irq_events;
        end else begin
            irq_status_q <= irq_status_q | irq_events;
        end
    end

    assign irq_o = |(irq_status_q & irq_mask_q);

    // first and second pin routing.
    // Pins are registered to keep glitches of the combine gate off the pads.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_timer_output_pin_o <= 1'b0;
            second_timer_output_pin_o <= 1'b0;
        end else begin
            first_timer_output_pin_o <=
                short_timer_control_q[dual_ctr_pkg::SHORT_FIRST_PIN_BIT] ?
                eight_bit_out_i : first_port_data_i;
            if (!demod_mode && timer_common_control_q[dual_ctr_pkg::COMMON_PIN_BIT]) begin
                second_timer_output_pin_o <= combined;
            end else begin
                second_timer_output_pin_o <= second_port_data_i;
            end
        end
    end

    sequence s_bus_request;
        cyc_i && stb_i && !ack_q;
    endsequence

    sequence s_capture_seen;
        edge_ev && short_timer_control_q[dual_ctr_pkg::SHORT_CAPTURE_IE_BIT]
            && irq_mask_q[dual_ctr_pkg::IRQ_CAPTURE_BIT];
    endsequence

    a_bus_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_request |=> ack_o ##1 !ack_o)
        else $error("Bus ack not given for exactly one cycle after request.");

    a_capture_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
        s_capture_seen |=> irq_o && capture_pulse_o)
        else $error("Capture with enable did not raise the interrupt.");

    a_timeout_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
        eight_bit_timeout_i && short_timer_control_q[dual_ctr_pkg::SHORT_COUNTER_IE_BIT]
        && irq_mask_q[dual_ctr_pkg::IRQ_TIMEOUT_BIT] |=> irq_o)
        else $error("Timeout with enable did not raise the interrupt.");

    a_first_pin_route: assert property (@(posedge clk_i) disable iff (rst_i)
        short_timer_control_q[dual_ctr_pkg::SHORT_FIRST_PIN_BIT]
        |=> first_timer_output_pin_o == $past(eight_bit_out_i))
        else $error("First pin does not follow the eight-bit output.");

    a_mode_reset_value: assert property (@(posedge clk_i)
        rst_i |=> !demod_mode && combine_or_edge_select == 2'h0)
        else $error("Mode or function field not cleared by reset.");

    a_second_pin_route: assert property (@(posedge clk_i) disable iff (rst_i)
        !demod_mode && timer_common_control_q[dual_ctr_pkg::COMMON_PIN_BIT]
        |=> second_timer_output_pin_o == $past(combined))
        else $error("Second pin does not carry the combined output.");

    // The unselected pin may toggle freely; only the chosen one may make edges.
    a_alt_source_only: assert property (@(posedge clk_i) disable iff (rst_i)
        timer_common_control_q[dual_ctr_pkg::COMMON_PIN_BIT]
        && $past(timer_common_control_q[dual_ctr_pkg::COMMON_PIN_BIT])
        && $stable(alt_level) |-> !edge_ev)
        else $error("Edge seen although the alternate source stood still.");

    a_cmp_source_only: assert property (@(posedge clk_i) disable iff (rst_i)
        !timer_common_control_q[dual_ctr_pkg::COMMON_PIN_BIT]
        && !$past(timer_common_control_q[dual_ctr_pkg::COMMON_PIN_BIT])
        && $stable(cmp_level) |-> !edge_ev)
        else $error("Edge seen although the comparator source stood still.");

    a_nor_combine: assert property (@(posedge clk_i) disable iff (rst_i)
        combine_or_edge_select == dual_ctr_pkg::FUNC_NOR
        |-> combined == !(eight_bit_out_i || sixteen_bit_out_i))
        else $error("NOR combine gives a wrong level.");

    a_edge_kind_match: assert property (@(posedge clk_i) disable iff (rst_i)
        (rise_ev |-> combine_or_edge_select != dual_ctr_pkg::EDGE_FALLING)
        and (fall_ev |-> combine_or_edge_select != dual_ctr_pkg::EDGE_RISING))
        else $error("An edge of the wrong kind was accepted.");

    a_reserved_edge_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        demod_mode && combine_or_edge_select == dual_ctr_pkg::EDGE_RESERVED |-> !edge_ev)
        else $error("Reserved edge code detected an edge.");

endmodule

`default_nettype wire

// file: pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module pin_model (
    // Clock.
    input wire logic clk_i,
    // Level wanted on the chosen source and which source carries it.
    input wire logic lvl_i,
    input wire logic use_alt_i,
    // Demodulator source pins.
    output logic comp_pin_o,
    output logic alt_pin_o
);
    logic [2:0] noise_q = 3'h0;

    // The idle source toggles every four cycles, slow enough to pass the pin
    // filter, so a leak from it shows up as extra edges.
    always_ff @(posedge clk_i) begin
        noise_q <= noise_q + 3'h1;
    end

    assign comp_pin_o = use_alt_i ? noise_q[2] : lvl_i;
    assign alt_pin_o = use_alt_i ? lvl_i : noise_q[2];
endmodule

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_top;
    localparam logic [5:0] A_SHORT = {dual_ctr_pkg::IDX_SHORT_CTRL, 2'b00};
    localparam logic [5:0] A_COMMON = {dual_ctr_pkg::IDX_COMMON_CTRL, 2'b00};
    localparam logic [5:0] A_STAT = {dual_ctr_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [5:0] A_MASK = {dual_ctr_pkg::IDX_IRQ_MASK, 2'b00};
    localparam logic [5:0] A_LOW = {dual_ctr_pkg::IDX_CAPTURE_LOW, 2'b00};
    localparam logic [5:0] A_HIGH = {dual_ctr_pkg::IDX_CAPTURE_HIGH, 2'b00};
    logic clk_i, rst_i, cyc, stb, we, e8, e16, tmo, pd1, pd2, lvl, use_alt;
    logic ack, comp_pin, alt_pin, pin1, pin2, cap, irq;
    logic [5:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [15:0] cnt16;
    logic [7:0] cfg, flags;
    int errors = 0;
    int n_compared = 0;
    int pulses = 0;
    int p0;
    int exp_n;

    // Free-running 250 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    dual_counter_transmit_demod_ctrl u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .eight_bit_out_i(e8), .sixteen_bit_out_i(e16), .eight_bit_timeout_i(tmo),
        .capture_count_i(cnt16), .first_port_data_i(pd1), .second_port_data_i(pd2),
        .comparator_capable_input_pin_i(comp_pin), .alternate_port_two_pin_i(alt_pin),
        .first_timer_output_pin_o(pin1), .second_timer_output_pin_o(pin2),
        .capture_pulse_o(cap), .irq_o(irq));

    pin_model u_pins (.clk_i(clk_i), .lvl_i(lvl), .use_alt_i(use_alt),
        .comp_pin_o(comp_pin), .alt_pin_o(alt_pin));

    // Counts one-cycle capture pulses; the main sequence takes a snapshot per case.
    always @(posedge clk_i) begin
        if (cap === 1'b1) pulses <= pulses + 1;
    end

    // Waits for ack as long as it takes; only the watchdog ends a hung transfer.
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        `CHK(q, {24'h0, e})
    endtask

    task automatic pulse_timeout();
        @(posedge clk_i);
        tmo <= 1'b1;
        @(posedge clk_i);
        tmo <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    function automatic logic comb(input logic [1:0] f, input logic a, input logic b);
        case (f)
            dual_ctr_pkg::FUNC_AND: return a & b;
            dual_ctr_pkg::FUNC_OR: return a | b;
            dual_ctr_pkg::FUNC_NOR: return ~(a | b);
            default: return ~(a & b);
        endcase
    endfunction

    task automatic print_verdict();
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Runs far longer than the tests need, so only a hang reaches it.
    initial begin
        #40000;
        errors++;
        print_verdict();
    end

    // Main sequence: reset values, transmit routing, timeout, demodulation.
    initial begin
        {cyc, stb, we, e8, e16, tmo, pd1, pd2, use_alt} = '0;
        lvl = 1'b1;
        adr = '0;
        wdat = '0;
        cnt16 = '0;
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_COMMON, dual_ctr_pkg::COMMON_CTRL_RESET);
        rd(A_SHORT, 8'h00);
        rd(A_MASK, 8'h00);
        rd(A_STAT, 8'h00);
        rd(6'h3C, 8'h00);
        // Every route, function and input pair; first pin carries the counter.
        wr(A_SHORT, 8'h01);
        for (int k = 0; k < 64; k++) begin
            wr(A_COMMON, {dual_ctr_pkg::MODE_TRANSMIT, k[5], k[4:3], 4'h0});
            @(posedge clk_i);
            e8 <= k[0];
            e16 <= k[1];
            pd1 <= k[2];
            pd2 <= ~k[2];
            repeat (2) @(posedge clk_i);
            `CHK(pin1, k[0])
            `CHK(pin2, k[5] ? comb(k[4:3], k[0], k[1]) : ~k[2])
        end
        @(posedge clk_i);
        e8 <= 1'b1;
        pd1 <= 1'b0;
        wr(A_SHORT, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK(pin1, 1'b0)
        // Timeout: masked, unmasked, then with its enable off.
        wr(A_SHORT, 8'h02);
        pulse_timeout();
        `CHK(irq, 1'b0)
        rd(A_STAT, 8'h02);
        rd(A_STAT, 8'h00);
        wr(A_MASK, 8'h02);
        pulse_timeout();
        `CHK(irq, 1'b1)
        rd(A_STAT, 8'h02);
        @(posedge clk_i);
        `CHK(irq, 1'b0)
        wr(A_SHORT, 8'h00);
        pulse_timeout();
        rd(A_STAT, 8'h00);
        // counters quiet before the mode change
        @(posedge clk_i);
        e8 <= 1'b0;
        e16 <= 1'b0;
        wr(A_SHORT, 8'h04);
        wr(A_MASK, 8'h01);
        wr(A_COMMON, 8'h80);
        // Each source and edge code sees one fall and one rise.
        for (int k = 0; k < 8; k++) begin
            cfg = {dual_ctr_pkg::MODE_DEMOD, k[2], k[1:0], 4'h0};
            use_alt <= k[2];
            cnt16 <= 16'hC030 + 16'(k * 257);
            wr(A_COMMON, cfg);
            repeat (10) @(posedge clk_i);
            wr(A_COMMON, cfg | 8'h03);
            xfer(1'b0, A_STAT, 8'h00);
            p0 = pulses;
            lvl <= 1'b0;
            repeat (10) @(posedge clk_i);
            lvl <= 1'b1;
            repeat (10) @(posedge clk_i);
            exp_n = (k[1:0] == 2'h2) ? 2 : ((k[1:0] == 2'h3) ? 0 : 1);
            flags = {6'h0, k[1:0] == 2'h1 || k[1:0] == 2'h2, k[1:0] == 2'h0 || k[1:0] == 2'h2};
            `CHK(pulses - p0, exp_n)
            `CHK(irq, exp_n != 0)
            rd(A_COMMON, cfg | flags);
            rd(A_STAT, (exp_n != 0) ? 8'h01 : 8'h00);
            if (exp_n != 0) begin
                rd(A_LOW, cnt16[7:0]);
                rd(A_HIGH, cnt16[15:8]);
            end
        end
        print_verdict();
    end
endmodule

`default_nettype wire
